//--- design/fcru_pkg.sv
package fcru_pkg;
  // bus widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int PADDR_W = 24;
  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_CMD   = 30'h00ff_e060;
  localparam logic [29:0] IDX_CTL   = 30'h00ff_e061;
  localparam logic [29:0] IDX_GUARD = 30'h00ff_e062;
  localparam logic [29:0] IDX_PAGE  = 30'h00ff_e064;
  localparam logic [29:0] IDX_KHZ   = 30'h00ff_e066;
  // command codes
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
  localparam logic [7:0] CMD_PERASE  = 8'h95;
  localparam logic [7:0] CMD_MERASE  = 8'h63;
  // status state field codes
  localparam logic [5:0] ST_IDLE   = 6'h00;
  localparam logic [5:0] ST_PROG   = 6'h08;
  localparam logic [5:0] ST_PERASE = 6'h10;
  localparam logic [5:0] ST_MERASE = 6'h20;
  // field positions
  localparam int CTL_AUX_BIT = 7;
  localparam int PAGE_LSB    = 3;
  localparam int PAGE_MSB    = 8;
  localparam int PADDR_LSB   = 11;
  localparam int PADDR_MSB   = 16;
  localparam int SECT_LSB    = 3;
  localparam logic [PADDR_W-1:0] AUX_AREA_SELECT_TOP = 24'h00_007f;
  // frequency register holds clock rate divided by this
  localparam logic [17:0] FREQ_DIV = 18'h0_03e8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {LK_LOCKED, LK_FIRST, LK_OPEN} fcru_lock_t;
  typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_PAGE, OP_MASS} fcru_op_t;

  typedef struct packed {
    logic               awHeld;
    logic [29:0]        awIdx;
    logic               wHeld;
    logic [31:0]        wData;
    logic [3:0]         wStrb;
    logic               bValid;
    logic [1:0]         bResp;
    logic               rValid;
    logic [31:0]        rData;
    logic [1:0]         rResp;
    fcru_lock_t         lockSt;
    fcru_op_t           op;
    logic               auxSel;
    logic [7:0]         guard;
    logic [5:0]         page;
    logic [15:0]        khz;
    logic [17:0]        usAcc;
    logic [23:0]        usLeft;
    logic [PADDR_W-1:0] progAddr;
    logic [15:0]        progData;
    logic               progStart;
    logic               eraseStart;
    logic               massStart;
    logic               infoHit;
  } fcru_state_t;

  localparam fcru_state_t STATE_RST = '0;
endpackage

//--- design/fcru_top.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] command location writes commands, reads status
// [RQ2] 73H then 8CH unlocks
// [RQ3] 95H while unlocked erases selected page
// [RQ4] 63H recognised as whole-array erase
// [RQ5] unknown or misordered command relocks
// [RQ6] status bit 7 shows unlock, resets 0
// [RQ7] state field codes idle/program/erase/mass
// [RQ8] status read has no side effect, bit6 zero
// [RQ9] aux bit maps aux_area_select area 0-7FH
// [RQ10] control bits 6..0 read zero
// [RQ11] guard bits readable, writes only set
// [RQ12] guarded sector refuses program and erase
// [RQ13] page field bits 8:3 drive address 16:11
// [RQ14] page erase fills page with FFFFH
// [RQ15] khz register paces program and erase
// [RQ16] software keeps clock 32kHz to 20MHz
// [RQ17] page write while unlocking relocks
// [RQ18] locked after reset
// [RQ19] finished page erase relocks
// [RQ20] program only words inside selected page
// [RQ21] state field returns idle when done
module fcru_top #(
  parameter int PROG_TIME_US   = 40,
  parameter int PERASE_TIME_US = 10000,
  parameter int MERASE_TIME_US = 20000
) (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic [fcru_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]                   awprot,
  input  wire logic                         awvalid,
  output logic                              awready,
  input  wire logic [fcru_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output logic                              wready,
  output logic [1:0]                        bresp,
  output logic                              bvalid,
  input  wire logic                         bready,
  input  wire logic [fcru_pkg::ADDR_W-1:0]  araddr,
  input  wire logic [2:0]                   arprot,
  input  wire logic                         arvalid,
  output logic                              arready,
  output logic [fcru_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                        rresp,
  output logic                              rvalid,
  input  wire logic                         rready,
  input  wire logic                         massEraseAllow,
  input  wire logic                         progWrValid,
  input  wire logic [fcru_pkg::PADDR_W-1:0] progWrAddr,
  input  wire logic [15:0]                  progWrData,
  output logic                              progWrReady,
  input  wire logic [fcru_pkg::PADDR_W-1:0] fetchAddr,
  output logic                              infoAreaHit,
  output logic                              auxAreaSelect,
  output logic                              flashProgStart,
  output logic [fcru_pkg::PADDR_W-1:0]      flashProgAddr,
  output logic [15:0]                       flashProgData,
  output logic                              flashEraseStart,
  output logic                              flashMassStart,
  output logic [5:0]                        flashErasePage,
  output logic                              flashBusy
);
  import fcru_pkg::*;

  fcru_state_t s;
  fcru_state_t n;
  logic        doWrite;
  logic        cmdWr;
  logic [7:0]  cmdVal;
  logic [5:0]  statField;
  logic [7:0]  statusByte;
  logic [17:0] accSum;
  logic        usTick;
  logic        progTake;
  logic        inPage;
  logic        pageFree;
  logic [29:0] arIdx;
  logic [15:0] mergedHalf;

  // handshake readies straight from state
  assign awready     = !s.awHeld;
  assign wready      = !s.wHeld;
  assign arready     = !s.rValid;
  assign progWrReady = (s.op == OP_IDLE);
  assign arIdx       = araddr[31:2];

  // state field and status byte
  always_comb begin
    case (s.op)
      OP_PROG: statField = ST_PROG; // [RQ7]
      OP_PAGE: statField = ST_PERASE;
      OP_MASS: statField = ST_MERASE;
      default: statField = ST_IDLE;
    endcase
  end
  assign statusByte = {s.lockSt == LK_OPEN, 1'b0, statField}; // [RQ6] [RQ8]

  // a write fires once both address and data are held
  assign doWrite    = s.awHeld && s.wHeld && !s.bValid;
  assign cmdWr      = doWrite && (s.awIdx == IDX_CMD) && s.wStrb[0];
  assign cmdVal     = s.wData[7:0];
  assign mergedHalf = {s.wStrb[1] ? s.wData[15:8] : 8'h00,
                       s.wStrb[0] ? s.wData[7:0] : 8'h00};

  // microsecond pacing: each cycle is 1000/khz us, so add 1000 and
  // subtract khz per elapsed us; below 1 MHz time runs slow
  assign accSum = s.usAcc + FREQ_DIV; // [RQ15]
  assign usTick = (accSum >= {2'b00, s.khz});

  // program word must sit in the open page of an unguarded sector
  assign inPage   = (progWrAddr[PADDR_W-1:PADDR_MSB+1] == '0) &&
                    (progWrAddr[PADDR_MSB:PADDR_LSB] == s.page);
  assign pageFree = !s.guard[s.page[5:SECT_LSB]];
  assign progTake = progWrValid && progWrReady;

  always_comb begin
    n            = s;
    n.progStart  = 1'b0;
    n.eraseStart = 1'b0;
    n.massStart  = 1'b0;
    n.infoHit    = s.auxSel && (fetchAddr <= AUX_AREA_SELECT_TOP); // [RQ9]

    // read channel: one read at a time, answered the next cycle
    if (s.rValid && rready) begin
      n.rValid = 1'b0;
    end
    if (!s.rValid && arvalid) begin
      n.rValid = 1'b1;
      n.rResp  = RESP_OKAY;
      case (arIdx)
        IDX_CMD:   n.rData = {24'h00_0000, statusByte}; // [RQ1] [RQ8]
        IDX_CTL:   n.rData = {24'h00_0000, s.auxSel, 7'h00}; // [RQ10]
        IDX_GUARD: n.rData = {24'h00_0000, s.guard}; // [RQ11]
        IDX_PAGE:  n.rData = {16'h0000, 7'h00, s.page, 3'h0}; // [RQ13]
        IDX_KHZ:   n.rData = {16'h0000, s.khz};
        default: begin
          n.rData = 32'h0000_0000;
          n.rResp = RESP_SLVERR;
        end
      endcase
    end

    // write address and data may arrive in either order
    if (awvalid && !s.awHeld) begin
      n.awHeld = 1'b1;
      n.awIdx  = awaddr[31:2];
    end
    if (wvalid && !s.wHeld) begin
      n.wHeld = 1'b1;
      n.wData = wdata;
      n.wStrb = wstrb;
    end
    if (s.bValid && bready) begin
      n.bValid = 1'b0;
    end

    // timed operation in progress
    if (s.op != OP_IDLE) begin
      if (usTick) begin
        n.usAcc = accSum - {2'b00, s.khz};
        if (s.usLeft != '0) begin
          n.usLeft = s.usLeft - 24'h00_0001;
        end
      end else begin
        n.usAcc = accSum;
      end
      if (s.usLeft == '0) begin
        n.op = OP_IDLE; // [RQ21]
        if (s.op == OP_PAGE) begin
          n.lockSt = LK_LOCKED; // [RQ19]
        end
      end
    end

    // program port: words outside the page are silently dropped
    if (progTake && s.lockSt == LK_OPEN && inPage && pageFree) begin // [RQ20] [RQ12]
      n.op        = OP_PROG;
      n.usLeft    = 24'(PROG_TIME_US);
      n.usAcc     = '0;
      n.progStart = 1'b1;
      n.progAddr  = progWrAddr;
      n.progData  = progWrData;
    end

    if (doWrite) begin
      n.awHeld = 1'b0;
      n.wHeld  = 1'b0;
      n.bValid = 1'b1;
      n.bResp  = RESP_OKAY;
      case (s.awIdx)
        IDX_CMD: begin
          if (s.wStrb[0]) begin
            // command sequencer; anything unexpected relocks
            n.lockSt = LK_LOCKED; // [RQ5]
            case (s.lockSt)
              LK_LOCKED: begin
                if (cmdVal == CMD_UNLOCK1) begin
                  n.lockSt = LK_FIRST; // [RQ2]
                end
              end
              LK_FIRST: begin
                if (cmdVal == CMD_UNLOCK2) begin
                  n.lockSt = LK_OPEN; // [RQ2]
                end
              end
              LK_OPEN: begin
                if (cmdVal == CMD_PERASE && s.op == OP_IDLE &&
                    pageFree) begin
                  // array fills page with all ones; lock drops at end
                  n.lockSt     = LK_OPEN; // [RQ3] [RQ14]
                  n.op         = OP_PAGE;
                  n.usLeft     = 24'(PERASE_TIME_US);
                  n.usAcc      = '0;
                  n.eraseStart = 1'b1;
                end else if (cmdVal == CMD_MERASE && s.op == OP_IDLE &&
                             massEraseAllow) begin
                  // user code cannot mass erase unless allowed
                  n.lockSt    = LK_OPEN; // [RQ4]
                  n.op        = OP_MASS;
                  n.usLeft    = 24'(MERASE_TIME_US);
                  n.usAcc     = '0;
                  n.massStart = 1'b1;
                end
              end
              default: n.lockSt = LK_LOCKED;
            endcase
          end
        end
        IDX_CTL: begin
          if (s.wStrb[0]) begin
            n.auxSel = s.wData[CTL_AUX_BIT]; // [RQ10]
          end
        end
        IDX_GUARD: begin
          // set-only: a zero never clears protection
          if (s.wStrb[0]) begin
            n.guard = s.guard | s.wData[7:0]; // [RQ11]
          end
        end
        IDX_PAGE: begin
          if (s.lockSt != LK_LOCKED) begin
            n.lockSt = LK_LOCKED; // [RQ17]
          end else if (s.wStrb[0] || s.wStrb[1]) begin
            n.page = {s.wStrb[1] ? s.wData[PAGE_MSB] : s.page[5],
                      s.wStrb[0] ? s.wData[PAGE_MSB-1:PAGE_LSB]
                                 : s.page[4:0]}; // [RQ13]
          end
        end
        IDX_KHZ: begin
          n.khz = {s.wStrb[1] ? mergedHalf[15:8] : s.khz[15:8],
                   s.wStrb[0] ? mergedHalf[7:0] : s.khz[7:0]}; // [RQ15]
        end
        default: n.bResp = RESP_SLVERR;
      endcase
    end
  end

  // single state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s <= STATE_RST; // [RQ18]
    end else begin
      s <= n;
    end
  end

  // outputs from registered state
  assign bvalid          = s.bValid;
  assign bresp           = s.bResp;
  assign rvalid          = s.rValid;
  assign rdata           = s.rData;
  assign rresp           = s.rResp;
  assign infoAreaHit     = s.infoHit;
  assign auxAreaSelect   = s.auxSel;
  assign flashProgStart  = s.progStart;
  assign flashProgAddr   = s.progAddr;
  assign flashProgData   = s.progData;
  assign flashEraseStart = s.eraseStart;
  assign flashMassStart  = s.massStart;
  assign flashErasePage  = s.page;
  assign flashBusy       = (s.op != OP_IDLE);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence seq_first_code;
    cmdWr && cmdVal == CMD_UNLOCK1 && s.lockSt == LK_LOCKED;
  endsequence
  sequence seq_second_code;
    cmdWr && cmdVal == CMD_UNLOCK2 && s.lockSt == LK_FIRST;
  endsequence

  // writes take several cycles each, so the codes are never adjacent
  a_unlock_pair: assert property (seq_first_code ##[1:50] // [RQ2]
    seq_second_code |=> s.lockSt == LK_OPEN)
    else $error("unlock pair failed");
  a_unlock_first: assert property (seq_first_code // [RQ2]
    |=> s.lockSt == LK_FIRST) else $error("first code not held");
  a_bad_cmd_locks: assert property (cmdWr && cmdVal != CMD_UNLOCK1 && // [RQ5]
    cmdVal != CMD_UNLOCK2 && cmdVal != CMD_PERASE && cmdVal != CMD_MERASE
    |=> s.lockSt == LK_LOCKED) else $error("bad command kept lock");
  a_erase_start: assert property (cmdWr && cmdVal == CMD_PERASE && // [RQ3]
    s.lockSt == LK_OPEN && s.op == OP_IDLE && pageFree
    |=> flashEraseStart && statField == ST_PERASE)
    else $error("page erase not started");
  a_erase_guarded: assert property (cmdWr && cmdVal == CMD_PERASE && // [RQ12]
    !pageFree |=> !flashEraseStart) else $error("guarded page erased");
  a_mass_start: assert property (cmdWr && cmdVal == CMD_MERASE && // [RQ4]
    s.lockSt == LK_OPEN && s.op == OP_IDLE && massEraseAllow
    |=> flashMassStart && statField == ST_MERASE)
    else $error("mass erase not started");
  a_erase_relock: assert property (s.op == OP_PAGE // [RQ19]
    ##1 s.op == OP_IDLE |-> s.lockSt == LK_LOCKED)
    else $error("erase end kept unlock");
  a_page_relock: assert property (doWrite && s.awIdx == IDX_PAGE && // [RQ17]
    s.lockSt != LK_LOCKED |=> s.lockSt == LK_LOCKED && $stable(s.page))
    else $error("page write kept unlock");
  a_status_bit: assert property (arvalid && arready && // [RQ6]
    arIdx == IDX_CMD |=> rdata[7] == ($past(s.lockSt) == LK_OPEN) &&
    rdata[6] == 1'b0) else $error("status unlock bit wrong");
  a_status_idle: assert property (arvalid && arready && // [RQ7]
    arIdx == IDX_CMD && s.op == OP_IDLE |=> rdata[5:0] == ST_IDLE)
    else $error("idle state code wrong");
  a_ctl_reserved: assert property (arvalid && arready && // [RQ10]
    arIdx == IDX_CTL |=> rdata[6:0] == 7'h00)
    else $error("control reserved bits set");
  a_guard_sticky: assert property ( // [RQ11]
    ($past(s.guard) & ~s.guard) == 8'h00) else $error("guard bit cleared");
  a_aux_area_select_map: assert property (infoAreaHit == // [RQ9]
    ($past(auxAreaSelect) && $past(fetchAddr) <= AUX_AREA_SELECT_TOP))
    else $error("aux_area_select area decode wrong");
  a_prog_outside: assert property (progTake && !inPage && // [RQ20]
    s.op == OP_IDLE |=> !flashProgStart) else $error("program outside page");
  a_prog_guarded: assert property (progTake && !pageFree // [RQ12]
    |=> !flashProgStart) else $error("guarded sector programmed");
  a_prog_code: assert property (flashProgStart // [RQ7] [RQ13]
    |-> statField == ST_PROG &&
    flashProgAddr[PADDR_MSB:PADDR_LSB] == s.page)
    else $error("program state code wrong");
  a_busy_level: assert property (flashProgStart || flashEraseStart || // [RQ7]
    flashMassStart |-> flashBusy) else $error("start without busy");
  a_op_finish: assert property (s.op != OP_IDLE && s.usLeft == '0 // [RQ21]
    |=> statField == ST_IDLE || flashProgStart)
    else $error("operation did not end");
endmodule // fcru_top

//--- tb/fcru_flash_model.sv
`timescale 1ns/1ps
// behavioural flash array: keeps words, counts every started operation
module fcru_flash_model (
  input wire logic                         clk,
  input wire logic                         rstn,
  input wire logic                         progStart,
  input wire logic [fcru_pkg::PADDR_W-1:0] progAddr,
  input wire logic [15:0]                  progData,
  input wire logic                         eraseStart,
  input wire logic [5:0]                   erasePage,
  input wire logic                         massStart
);
  import fcru_pkg::*;
  logic [15:0] mem [logic [23:0]];
  int          nProg = 0;
  int          nErase = 0;
  int          nMass = 0;

  // absent words read as erased
  function automatic logic [15:0] peek(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction

  // programming only clears bits, so a second write can never set one
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nProg = 0;
    end else if (progStart) begin
      mem[progAddr] = peek(progAddr) & progData;
      nProg++;
    end
  end

  // page is address bits 16:11, 2048 words each
  always @(posedge clk) begin
    if (eraseStart) begin
      for (int i = 0; i < 2048; i++) begin
        mem.delete({7'h0, erasePage, 11'(i)});
      end
      nErase++;
    end
    if (massStart) begin
      mem.delete();
      nMass++;
    end
  end
endmodule // fcru_flash_model

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  import fcru_pkg::*;
  logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, massEraseAllow;
  logic        progWrValid, progWrReady, infoAreaHit, auxAreaSelect;
  logic        flashProgStart, flashEraseStart, flashMassStart, flashBusy;
  logic [31:0] awaddr, araddr, wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [23:0] progWrAddr, fetchAddr, flashProgAddr, pa;
  logic [15:0] progWrData, flashProgData, pd;
  logic [5:0]  flashErasePage, pg;
  logic [7:0]  gd, gx;
  logic [29:0] regIdx [5] = '{IDX_CMD, IDX_CTL, IDX_GUARD, IDX_PAGE, IDX_KHZ};
  logic [23:0] fTab [4] = '{24'h00_0000, 24'h00_007f, 24'h00_0080, 24'h01_0010};
  int          n_fail = 0;
  int          num_checks = 0;

  // short operation times keep the run brief
  fcru_top #(.PROG_TIME_US(2), .PERASE_TIME_US(5), .MERASE_TIME_US(5)) uut (
    .clk(clk), .rstn(rstn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .massEraseAllow(massEraseAllow),
    .progWrValid(progWrValid), .progWrAddr(progWrAddr),
    .progWrData(progWrData), .progWrReady(progWrReady),
    .fetchAddr(fetchAddr), .infoAreaHit(infoAreaHit),
    .auxAreaSelect(auxAreaSelect), .flashProgStart(flashProgStart),
    .flashProgAddr(flashProgAddr), .flashProgData(flashProgData),
    .flashEraseStart(flashEraseStart), .flashMassStart(flashMassStart),
    .flashErasePage(flashErasePage), .flashBusy(flashBusy));

  fcru_flash_model flashModel (
    .clk(clk), .rstn(rstn), .progStart(flashProgStart),
    .progAddr(flashProgAddr), .progData(flashProgData),
    .eraseStart(flashEraseStart), .erasePage(flashErasePage),
    .massStart(flashMassStart));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // expected status byte: unlock flag, reserved zero, state field
  function automatic logic [31:0] stat(input logic u, input logic [5:0] f);
    return {24'h0, u, 1'b0, f};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // each channel released at the edge its ready is seen
  task automatic axWrite(input logic [29:0] idx, input logic [31:0] d,
                         input logic [3:0] s, output logic [1:0] r);
    int n = 0;
    bit got = 1'b0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && n < 1000) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
    if (!got) n_fail++;
  endtask

  task automatic axRead(input logic [29:0] idx, output logic [31:0] d,
                        output logic [1:0] r);
    int n = 0;
    bit got = 1'b0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 1000) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
    if (!got) n_fail++;
  endtask

  task automatic cmd(input logic [7:0] c);
    axWrite(IDX_CMD, {24'h0, c}, 4'h1, rs);
  endtask

  task automatic chkStat(input string nm, input logic u, input logic [5:0] f);
    axRead(IDX_CMD, rd, rs);
    chk(nm, rd, stat(u, f));
  endtask

  // relock, then page, then the two unlock codes
  task automatic unlock(input logic [5:0] p);
    // relock first: a page write while open is refused and relocks
    cmd(8'h00);
    axWrite(IDX_PAGE, {23'h0, p, 3'h0}, 4'h3, rs);
    cmd(CMD_UNLOCK1);
    cmd(CMD_UNLOCK2);
  endtask

  task automatic progWord(input logic [23:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge clk);
    progWrAddr <= a;
    progWrData <= d;
    progWrValid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (progWrReady !== 1'b1 && n < 1000);
    progWrValid <= 1'b0;
  endtask

  task automatic waitIdle();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (flashBusy !== 1'b0 && n < 2000);
    if (flashBusy !== 1'b0) n_fail++;
  endtask

  // watchdog: the whole sequence needs well under 20k cycles
  initial begin
    #200_000;
    n_fail++;
    summarize();
  end

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {massEraseAllow, progWrValid, awaddr, araddr, wdata, wstrb} = '0;
    {progWrAddr, progWrData, fetchAddr} = '0;
    void'($urandom(32'h0000_cb78));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    foreach (regIdx[i]) begin
      axRead(regIdx[i], rd, rs);
      chk("reset value", rd, 32'h0);
    end
    axRead(30'h00ff_e063, rd, rs);
    chk("unmapped read", rs, RESP_SLVERR);
    axWrite(30'h00ff_e063, 32'hffff_ffff, 4'hf, rs);
    chk("unmapped write", rs, RESP_SLVERR);
    $display("test reset finished");
    // 20 MHz setting keeps operations within the supported span
    axWrite(IDX_KHZ, 32'hffff_4e20, 4'hf, rs);
    axRead(IDX_KHZ, rd, rs);
    chk("khz", rd, 32'h0000_4e20);
    pg = 6'($urandom);
    axWrite(IDX_PAGE, {16'hffff, 7'h7f, pg, 3'h7}, 4'hf, rs);
    axRead(IDX_PAGE, rd, rs);
    chk("page", rd, {23'h0, pg, 3'h0});
    for (int a = 1; a >= 0; a--) begin
      axWrite(IDX_CTL, {24'h0, a[0], 7'h7f}, 4'h1, rs);
      axRead(IDX_CTL, rd, rs);
      chk("control", rd, {24'h0, a[0], 7'h0});
      chk("aux select", auxAreaSelect, a[0]);
      foreach (fTab[j]) begin
        fetchAddr <= fTab[j];
        repeat (2) @(posedge clk);
        chk("aux_area_select hit", infoAreaHit, a[0] && fTab[j] <= 24'h00_007f);
      end
    end
    $display("test registers finished");
    unlock(pg);
    chkStat("unlocked", 1'b1, ST_IDLE);
    chkStat("status reread", 1'b1, ST_IDLE);
    gx = 8'($urandom);
    if (gx inside {CMD_UNLOCK1, CMD_UNLOCK2, CMD_PERASE, CMD_MERASE}) gx = 8'h00;
    cmd(gx);
    chkStat("bad code", 1'b0, ST_IDLE);
    cmd(CMD_UNLOCK1);
    chkStat("first step", 1'b0, ST_IDLE);
    cmd(CMD_PERASE);
    // a relocked unit must not open on a lone second code
    cmd(CMD_UNLOCK2);
    chkStat("misordered", 1'b0, ST_IDLE);
    unlock(pg);
    axWrite(IDX_PAGE, {23'h0, pg, 3'h0}, 4'h3, rs);
    chkStat("page relock", 1'b0, ST_IDLE);
    $display("test lock finished");
    unlock(pg);
    pa = {7'h0, pg, 11'($urandom)};
    pd = 16'($urandom);
    progWord(pa, pd);
    chkStat("programming", 1'b1, ST_PROG);
    waitIdle();
    chk("prog count", flashModel.nProg, 1);
    chk("prog addr", flashProgAddr, pa);
    chk("word", flashModel.peek(pa), pd);
    chkStat("prog done", 1'b1, ST_IDLE);
    progWord(pa ^ 24'h00_0800, pd);
    waitIdle();
    chk("outside page", flashModel.nProg, 1);
    cmd(CMD_PERASE);
    chkStat("page erase", 1'b1, ST_PERASE);
    waitIdle();
    chk("erase count", flashModel.nErase, 1);
    chk("erase page", flashErasePage, pg);
    chk("erased word", flashModel.peek(pa), 16'hffff);
    chkStat("relocked", 1'b0, ST_IDLE);
    massEraseAllow <= 1'b1;
    unlock(pg);
    cmd(CMD_MERASE);
    chkStat("mass erase", 1'b1, ST_MERASE);
    waitIdle();
    chk("mass count", flashModel.nMass, 1);
    $display("test operations finished");
    gd = 8'($urandom) | 8'h01;
    axWrite(IDX_GUARD, {24'h0, gd}, 4'h1, rs);
    axWrite(IDX_GUARD, 32'h0, 4'h1, rs);
    axRead(IDX_GUARD, rd, rs);
    chk("guard kept", rd, {24'h0, gd});
    gx = 8'($urandom);
    axWrite(IDX_GUARD, {24'h0, gx}, 4'h1, rs);
    axRead(IDX_GUARD, rd, rs);
    chk("guard set", rd, {24'h0, gd | gx});
    // pages 0..7 sit in the guarded lowest sector
    pg = {3'h0, 3'($urandom)};
    unlock(pg);
    progWord({7'h0, pg, 11'h000}, 16'h0000);
    waitIdle();
    chk("guarded prog", flashModel.nProg, 1);
    cmd(CMD_PERASE);
    waitIdle();
    chk("guarded erase", flashModel.nErase, 1);
    $display("test guard finished");
    summarize();
  end
endmodule // tb
